/* File: rtl/iodt_consts.svh */
// Offsets, field positions, reset values and clock figures of the decode timing block.
// Assumes inclusion by bare name from design files only.
`ifndef IODT_CONSTS_SVH
`define IODT_CONSTS_SVH

// ==========================================
// Register map
`define IODT_CTRL_OFS 8'h00
`define IODT_STAT_OFS 8'h04
`define IODT_CNT_OFS 8'h08
// ==========================================
// Control fields
`define IODT_CTRL_R_LSB 0
`define IODT_CTRL_B_LSB 4
`define IODT_CTRL_W_LSB 8
`define IODT_CTRL_IDX_BIT 12
`define IODT_CTRL_DI_BIT 13
`define IODT_CTRL_RST 32'h0000_0212
// ==========================================
// Clock figures
`define IODT_FAST_R 4'h2
`define IODT_MISALIGN_CLKS 12'h003
`define IODT_TLB_CLKS0 12'h00D
`define IODT_TLB_CLKS1 12'h015
`define IODT_TLB_CLKS2 12'h01C
`define IODT_BASE_DEP_CLKS 12'h001
`define IODT_MAY_CLKS 12'h001
`define IODT_INV_CLKS 12'h001

`endif

/* File: rtl/iodt_pkg.sv */
// Types shared by the decode timing block.
// Assumes nothing of its surroundings.
package iodt_pkg;
  typedef enum logic [4:0] {
    IODT_UNKNOWN, IODT_MOVE_STORE, IODT_MOVE_LOAD, IODT_MOVE_IMM, IODT_MOVE_ACC_LD,
    IODT_MOVE_ACC_ST, IODT_EXTEND, IODT_PUSH_REG, IODT_PUSH_MEM, IODT_PUSH_IMM,
    IODT_PUSH_ALL, IODT_POP_REG, IODT_POP_MEM, IODT_POP_ALL, IODT_EXCH_REG,
    IODT_EXCH_MEM, IODT_NOOP, IODT_LEA
  } iodt_form_t;
endpackage

/* File: rtl/iodt_decode.sv */
// Decoder and latency model for integer data-movement instructions.
// Assumes synchronous inputs, one request at a time, answer one cycle later.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`include "iodt_consts.svh"

module iodt_decode #(
  parameter int CW = 8
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic dec_valid,
  input wire logic [7:0] op_b0,
  input wire logic [7:0] op_b1,
  input wire logic [7:0] op_b2,
  input wire logic op_size32,
  input wire logic data_miss,
  input wire logic misaligned,
  input wire logic [3:0] fill_wait,
  input wire logic [3:0] bus_wait,
  input wire logic base_dep,
  input wire logic prev_stack,
  input wire logic wbuf_full,
  input wire logic [2:0] inv_cnt,
  input wire logic tlb_miss,
  input wire logic [1:0] tlb_wb,
  input wire logic jmp_miss,
  input wire logic [1:0] jmp_span,
  input wire logic seq_unaligned,
  output logic res_valid,
  output logic res_known,
  output iodt_pkg::iodt_form_t res_form,
  output logic res_wide,
  output logic res_mem,
  output logic res_zext,
  output logic res_bus_start,
  output logic [CW-1:0] res_clocks
);

  // ==========================================
  // Helpers
  function automatic logic is_reg_mode(input logic [7:0] modrm);
    is_reg_mode = (modrm[7:6] == 2'h3);
  endfunction

  function automatic logic has_index(input logic [7:0] modrm, input logic [7:0] sib);
    has_index = !is_reg_mode(modrm) && (modrm[2:0] == 3'h4) && (sib[5:3] != 3'h4);
  endfunction

  function automatic logic has_disp(input logic [7:0] modrm);
    has_disp = (modrm[7:6] == 2'h1) || (modrm[7:6] == 2'h2) ||
               ((modrm[7:6] == 2'h0) && (modrm[2:0] == 3'h5));
  endfunction

  // ==========================================
  // Register file
  logic [31:0] ctrl_q;
  logic [31:0] cnt_q;
  logic [3:0] bus_r;
  logic [3:0] bus_b;
  logic [3:0] bus_w;
  logic take;

  assign bus_r = ctrl_q[`IODT_CTRL_R_LSB +: 4];
  assign bus_b = ctrl_q[`IODT_CTRL_B_LSB +: 4];
  assign bus_w = ctrl_q[`IODT_CTRL_W_LSB +: 4];
  assign take = ce && dec_valid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `IODT_CTRL_RST;
    end else if (ce && reg_wr && reg_addr == `IODT_CTRL_OFS) begin
      ctrl_q <= {18'h0, reg_wdata[13:0]};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
    end else if (ce && reg_wr && reg_addr == `IODT_CNT_OFS) begin
      cnt_q <= 32'h0000_0000;
    end else if (take) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // Unmapped reads answer zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          `IODT_CTRL_OFS: reg_rdata <= ctrl_q;
          `IODT_STAT_OFS: reg_rdata <= {18'h0, res_known, res_form, 8'(res_clocks)};
          `IODT_CNT_OFS: reg_rdata <= cnt_q;
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================
  // Decode
  iodt_pkg::iodt_form_t form;
  logic [7:0] modrm;
  logic [7:0] sib;
  logic known;
  logic wide;
  logic mem;
  logic rd_acc;
  logic wr_acc;
  logic stack;
  logic zext;
  logic disp_imm;
  logic [11:0] base;
  logic [11:0] miss_pen;

  always_comb begin
    form = iodt_pkg::IODT_UNKNOWN;
    modrm = op_b1;
    sib = op_b2;
    known = 1'b1;
    wide = 1'b1;
    mem = 1'b0;
    rd_acc = 1'b0;
    wr_acc = 1'b0;
    stack = 1'b0;
    zext = 1'b0;
    disp_imm = 1'b0;
    base = 12'h001;
    miss_pen = 12'h000;
    if (op_b0 == 8'h0F && op_b1[7:4] == 4'hB && op_b1[2:1] == 2'h3) begin
      form = iodt_pkg::IODT_EXTEND;
      modrm = op_b2;
      sib = 8'h00;
      wide = op_b1[0];
      zext = !op_b1[3];
      mem = !is_reg_mode(op_b2);
      rd_acc = mem;
      base = 12'h003;
      miss_pen = 12'h002;
    end else if (op_b0[7:1] == 7'h44) begin
      form = iodt_pkg::IODT_MOVE_STORE;
      wide = op_b0[0];
      mem = !is_reg_mode(op_b1);
      wr_acc = mem;
    end else if (op_b0 == 8'h8D) begin
      form = iodt_pkg::IODT_LEA;
      base = has_index(op_b1, op_b2) ? 12'h002 : 12'h001;
    end else if (op_b0[7:1] == 7'h45) begin
      form = iodt_pkg::IODT_MOVE_LOAD;
      wide = op_b0[0];
      mem = !is_reg_mode(op_b1);
      rd_acc = mem;
      miss_pen = 12'h002;
    end else if (op_b0[7:4] == 4'hB) begin
      form = iodt_pkg::IODT_MOVE_IMM;
      wide = op_b0[3];
    end else if (op_b0[7:1] == 7'h63 && op_b1[5:3] == 3'h0) begin
      form = iodt_pkg::IODT_MOVE_IMM;
      wide = op_b0[0];
      mem = !is_reg_mode(op_b1);
      wr_acc = mem;
      disp_imm = mem && has_disp(op_b1);
    end else if (op_b0[7:1] == 7'h50) begin
      form = iodt_pkg::IODT_MOVE_ACC_LD;
      wide = op_b0[0];
      mem = 1'b1;
      rd_acc = 1'b1;
      miss_pen = 12'h002;
    end else if (op_b0[7:1] == 7'h51) begin
      form = iodt_pkg::IODT_MOVE_ACC_ST;
      wide = op_b0[0];
      mem = 1'b1;
      wr_acc = 1'b1;
    end else if (op_b0[7:3] == 5'h0A) begin
      form = iodt_pkg::IODT_PUSH_REG;
      stack = 1'b1;
      wr_acc = 1'b1;
    end else if (op_b0 == 8'hFF && op_b1[5:3] == 3'h6) begin
      form = is_reg_mode(op_b1) ? iodt_pkg::IODT_PUSH_REG : iodt_pkg::IODT_PUSH_MEM;
      stack = 1'b1;
      mem = !is_reg_mode(op_b1);
      rd_acc = mem;
      wr_acc = 1'b1;
      base = 12'h004;
      miss_pen = 12'h001;
    end else if (op_b0 == 8'h68 || op_b0 == 8'h6A) begin
      form = iodt_pkg::IODT_PUSH_IMM;
      stack = 1'b1;
      wr_acc = 1'b1;
    end else if (op_b0 == 8'h60) begin
      form = iodt_pkg::IODT_PUSH_ALL;
      stack = 1'b1;
      wr_acc = 1'b1;
      base = 12'h00B;
    end else if (op_b0[7:3] == 5'h0B) begin
      form = iodt_pkg::IODT_POP_REG;
      stack = 1'b1;
      rd_acc = 1'b1;
      miss_pen = 12'h002;
    end else if (op_b0 == 8'h8F && op_b1[5:3] == 3'h0) begin
      form = is_reg_mode(op_b1) ? iodt_pkg::IODT_POP_REG : iodt_pkg::IODT_POP_MEM;
      stack = 1'b1;
      mem = !is_reg_mode(op_b1);
      rd_acc = 1'b1;
      wr_acc = mem;
      base = mem ? 12'h005 : 12'h004;
      miss_pen = mem ? 12'h002 : 12'h001;
    end else if (op_b0 == 8'h61) begin
      form = iodt_pkg::IODT_POP_ALL;
      stack = 1'b1;
      rd_acc = 1'b1;
      base = 12'h009;
      miss_pen = op_size32 ? 12'h00F : 12'h007;
    end else if (op_b0 == 8'h90) begin
      form = iodt_pkg::IODT_NOOP;
    end else if (op_b0[7:3] == 5'h12) begin
      form = iodt_pkg::IODT_EXCH_REG;
      base = 12'h003;
    end else if (op_b0[7:1] == 7'h43) begin
      form = is_reg_mode(op_b1) ? iodt_pkg::IODT_EXCH_REG : iodt_pkg::IODT_EXCH_MEM;
      wide = op_b0[0];
      mem = !is_reg_mode(op_b1);
      rd_acc = mem;
      wr_acc = mem;
      base = mem ? 12'h005 : 12'h003;
    end else begin
      known = 1'b0;
      base = 12'h000;
    end
  end

  // ==========================================
  // Penalties
  logic miss_hit;
  logic ea_calc;
  logic [11:0] pen;
  logic [11:0] total;
  logic [11:0] r12;
  logic [11:0] b3;

  assign r12 = {8'h00, bus_r};
  assign b3 = 12'({8'h00, bus_b} * 12'h003);
  // Miss only counts for forms that read data
  assign miss_hit = known && rd_acc && data_miss && (miss_pen != 12'h000);
  assign ea_calc = mem || stack || (form == iodt_pkg::IODT_LEA);

  always_comb begin
    pen = 12'h000;
    if (miss_hit) begin
      // Figures assume 2-1-2; slower buses pay the difference once
      pen = pen + miss_pen + r12 - {8'h00, `IODT_FAST_R};
      pen = pen + {8'h00, fill_wait};
      if (form == iodt_pkg::IODT_POP_ALL && seq_unaligned) begin
        pen = pen + r12 + b3;
      end
    end
    if (known && (rd_acc || wr_acc) && fill_wait != 4'h0 && !miss_hit) begin
      pen = pen + {8'h00, fill_wait};
    end
    if (known && rd_acc) begin
      pen = pen + {8'h00, bus_wait};
    end
    if (known && (mem || stack) && misaligned) begin
      pen = pen + `IODT_MISALIGN_CLKS;
    end
    if (known && ea_calc && base_dep && !(stack && prev_stack)) begin
      pen = pen + `IODT_BASE_DEP_CLKS;
    end
    if (known && mem && has_index(modrm, sib) && ctrl_q[`IODT_CTRL_IDX_BIT]) begin
      pen = pen + `IODT_MAY_CLKS;
    end
    if (known && disp_imm && ctrl_q[`IODT_CTRL_DI_BIT]) begin
      pen = pen + `IODT_MAY_CLKS;
    end
    if (known && wr_acc && wbuf_full) begin
      pen = pen + {8'h00, bus_w};
    end
    if (known) begin
      pen = pen + 12'({9'h000, inv_cnt} * `IODT_INV_CLKS);
    end
    if (known && tlb_miss) begin
      case (tlb_wb)
        2'h0: pen = pen + `IODT_TLB_CLKS0;
        2'h1: pen = pen + `IODT_TLB_CLKS1;
        default: pen = pen + `IODT_TLB_CLKS2;
      endcase
    end
    if (known && jmp_miss) begin
      pen = pen + r12;
      if (jmp_span != 2'h0) begin
        pen = pen + b3;
      end
      if (jmp_span[1]) begin
        pen = pen + r12 + b3;
      end
    end
    total = base + pen;
  end

  // ==========================================
  // Result registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_valid <= 1'b0;
      res_bus_start <= 1'b0;
    end else if (ce) begin
      res_valid <= dec_valid;
      res_bus_start <= dec_valid && miss_hit;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_known <= 1'b0;
      res_form <= iodt_pkg::IODT_UNKNOWN;
      res_wide <= 1'b0;
      res_mem <= 1'b0;
      res_zext <= 1'b0;
      res_clocks <= '0;
    end else if (take) begin
      res_known <= known;
      res_form <= form;
      res_wide <= wide;
      res_mem <= mem;
      res_zext <= zext;
      // Saturates rather than wraps on absurd penalty stacks
      res_clocks <= (total > 12'((1 << CW) - 1)) ? {CW{1'b1}} : CW'(total);
    end
  end

  // ==========================================
  // Checks
  logic quiet;
  assign quiet = !data_miss && !misaligned && fill_wait == 4'h0 && bus_wait == 4'h0 &&
                 !base_dep && !wbuf_full && inv_cnt == 3'h0 && !tlb_miss && !jmp_miss;

  chk_noop_one_clk: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h90 && quiet |=> res_clocks == CW'(1) && res_valid)
    else $error("no-op latency wrong");
  chk_extend_base: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h0F && op_b1 == 8'hB6 && op_b2[7:6] == 2'h3 && quiet
    |=> res_clocks == CW'(3) && res_zext && !res_wide)
    else $error("extend latency or kind wrong");
  chk_load_miss: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h8B && op_b1 == 8'h03 && data_miss && !misaligned &&
    fill_wait == 4'h0 && bus_wait == 4'h0 && !base_dep && inv_cnt == 3'h0 && !tlb_miss &&
    !jmp_miss && bus_r == 4'h2 |=> res_clocks == CW'(3) && res_bus_start)
    else $error("load miss latency wrong");
  chk_reg_no_miss: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h8B && op_b1[7:6] == 2'h3 |=> !res_bus_start && !res_mem)
    else $error("register operand started bus cycle");
  chk_misalign_add: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h89 && op_b1 == 8'h03 && misaligned && fill_wait == 4'h0 &&
    !base_dep && !wbuf_full && inv_cnt == 3'h0 && !tlb_miss && !jmp_miss
    |=> res_clocks == CW'(4))
    else $error("misaligned penalty wrong");
  chk_tlb_two: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h90 && tlb_miss && tlb_wb == 2'h2 && inv_cnt == 3'h0 &&
    !jmp_miss |=> res_clocks == CW'(29))
    else $error("translation miss penalty wrong");
  chk_stack_pair: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0[7:3] == 5'h0A && (quiet || (base_dep && prev_stack &&
    !misaligned && !wbuf_full && inv_cnt == 3'h0 && !tlb_miss && !jmp_miss &&
    fill_wait == 4'h0)) |=> res_clocks == CW'(1))
    else $error("push after stack op stalled");
  chk_wbuf_full: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h50 && wbuf_full && !base_dep && !misaligned &&
    inv_cnt == 3'h0 && !tlb_miss && !jmp_miss && fill_wait == 4'h0
    |=> res_clocks == CW'(1) + CW'(bus_w))
    else $error("write buffer delay wrong");
  chk_lea_index: assert property (@(posedge clk) disable iff (!rstn)
    ce && dec_valid && op_b0 == 8'h8D && op_b1 == 8'h04 && op_b2 == 8'h08 && quiet
    |=> res_clocks == CW'(2) && res_valid)
    else $error("effective-address latency wrong");

endmodule // iodt_decode

/* File: tb/iodt_mem_model.sv */
// Far-side bus and memory model for the decode timing bench.
// Assumes the bench picks one condition set per request; answers are levels.
`timescale 1ns/1ps

// ==========================================
// Memory side conditions
module iodt_mem_model (
  input wire logic [3:0] mode,
  output logic data_miss,
  output logic [3:0] bus_wait,
  output logic [3:0] fill_wait,
  output logic [2:0] inv_cnt
);
  assign data_miss = mode[0];
  // Busy bus: reads wait three clocks beyond the fastest timing
  assign bus_wait = mode[1] ? 4'h3 : 4'h0;
  assign fill_wait = mode[2] ? 4'h2 : 4'h0;
  assign inv_cnt = mode[3] ? 3'h2 : 3'h0;
endmodule // iodt_mem_model

/* File: tb/tb_integer_op_decode_timing.sv */
// Self-checking bench of the decode timing block.
// Assumes the memory model answers combinationally to the chosen mode.
`timescale 1ns/1ps

module tb_integer_op_decode_timing;
  // ==========================================
  // Signals
  logic clk, rstn, ce, reg_wr, reg_rd, dec_valid, op_size32, misaligned, base_dep;
  logic prev_stack, wbuf_full, tlb_miss, jmp_miss, seq_unaligned, data_miss;
  logic [7:0] reg_addr, op_b0, op_b1, op_b2, res_clocks;
  logic [31:0] reg_wdata, reg_rdata, seed;
  logic [3:0] fill_wait, bus_wait, mode;
  logic [2:0] inv_cnt;
  logic [1:0] tlb_wb, jmp_span;
  logic res_valid, res_known, res_wide, res_mem, res_zext, res_bus_start;
  iodt_pkg::iodt_form_t res_form;
  int bad_count, cmp_count, cyc;

  iodt_decode #(.CW(8)) i_dut (.clk(clk), .rstn(rstn), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dec_valid(dec_valid), .op_b0(op_b0), .op_b1(op_b1), .op_b2(op_b2),
    .op_size32(op_size32), .data_miss(data_miss), .misaligned(misaligned),
    .fill_wait(fill_wait), .bus_wait(bus_wait), .base_dep(base_dep),
    .prev_stack(prev_stack), .wbuf_full(wbuf_full), .inv_cnt(inv_cnt),
    .tlb_miss(tlb_miss), .tlb_wb(tlb_wb), .jmp_miss(jmp_miss), .jmp_span(jmp_span),
    .seq_unaligned(seq_unaligned), .res_valid(res_valid), .res_known(res_known),
    .res_form(res_form), .res_wide(res_wide), .res_mem(res_mem), .res_zext(res_zext),
    .res_bus_start(res_bus_start), .res_clocks(res_clocks));

  iodt_mem_model i_mem (.mode(mode), .data_miss(data_miss), .bus_wait(bus_wait),
    .fill_wait(fill_wait), .inv_cnt(inv_cnt));

  // ==========================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Penalty vector: {span[1:0], jmp, wb[1:0], tlb, wbuf, stack, dep, misalign}
  task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2,
    input logic [9:0] pv, input logic [3:0] md, input int ck,
    input iodt_pkg::iodt_form_t fm, input int mm);
    @(posedge clk);
    dec_valid <= 1'b1;
    op_b0 <= b0;
    op_b1 <= b1;
    op_b2 <= b2;
    mode <= md;
    {jmp_span, jmp_miss, tlb_wb, tlb_miss, wbuf_full, prev_stack, base_dep, misaligned} <= pv;
    @(posedge clk);
    dec_valid <= 1'b0;
    mode <= 4'h0;
    {jmp_span, jmp_miss, tlb_wb, tlb_miss, wbuf_full, prev_stack, base_dep, misaligned} <= '0;
    #1;
    chk(32'(res_valid), 32'h1);
    chk(32'(res_clocks), 32'(ck));
    chk(32'(res_form), 32'(fm));
    chk(32'(res_known), 32'(fm != iodt_pkg::IODT_UNKNOWN));
    chk(32'(res_bus_start), 32'(md[0] && mm >= 1));
    if (mm >= 0) chk(32'(res_mem), 32'(mm[0]));
  endtask

  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================
  // Main sequence
  initial begin
    seed = 32'd19;
    {rstn, reg_wr, reg_rd, dec_valid, op_size32, seq_unaligned} = '0;
    {misaligned, base_dep, prev_stack, wbuf_full, tlb_miss, jmp_miss} = '0;
    {reg_addr, reg_wdata, op_b0, op_b1, op_b2, mode, tlb_wb, jmp_span} = '0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h00, 32'h0000_0212);
    wr(8'h0C, xs());
    rd(8'h0C, 32'h0);
    issue(8'h90, 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_NOOP, 0);
    rd(8'h04, 32'h2001 | (32'(iodt_pkg::IODT_NOOP) << 8));
    rd(8'h08, 32'h1);
    wr(8'h08, xs());
    rd(8'h08, 32'h0);
    issue(8'h89, 8'hC0, 8'h00, 10'h0, 4'h1, 1, iodt_pkg::IODT_MOVE_STORE, 0);
    issue(8'h8B, 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_MOVE_LOAD, 1);
    issue(8'h8B, 8'h03, 8'h00, 10'h0, 4'h1, 3, iodt_pkg::IODT_MOVE_LOAD, 1);
    issue(8'h8B, 8'hC0, 8'h00, 10'h0, 4'h1, 1, iodt_pkg::IODT_MOVE_LOAD, 0);
    issue(8'h89, 8'h03, 8'h00, 10'h1, 4'h0, 4, iodt_pkg::IODT_MOVE_STORE, 1);
    issue(8'h8B, 8'h00, 8'h00, 10'h2, 4'h0, 2, iodt_pkg::IODT_MOVE_LOAD, 1);
    issue(8'h8F, 8'h00, 8'h00, 10'h6, 4'h0, 5, iodt_pkg::IODT_POP_MEM, 1);
    issue(8'h50, 8'h00, 8'h00, 10'h6, 4'h0, 1, iodt_pkg::IODT_PUSH_REG, 0);
    issue(8'h8B, 8'h00, 8'h00, 10'h0, 4'h3, 6, iodt_pkg::IODT_MOVE_LOAD, 1);
    issue(8'h8B, 8'h00, 8'h00, 10'h0, 4'h5, 5, iodt_pkg::IODT_MOVE_LOAD, 1);
    issue(8'h8B, 8'h00, 8'h00, 10'h0, 4'h8, 3, iodt_pkg::IODT_MOVE_LOAD, 1);
    issue(8'h89, 8'h00, 8'h00, 10'h8, 4'h0, 3, iodt_pkg::IODT_MOVE_STORE, 1);
    issue(8'h50, 8'h00, 8'h00, 10'h8, 4'h0, 3, iodt_pkg::IODT_PUSH_REG, 0);
    for (int i = 0; i < 4; i++) begin
      issue(8'h90, 8'h00, 8'h00, 10'h10 | 10'(i << 5), 4'h0, (i == 0) ? 14 : (i == 1) ? 22 : 29,
        iodt_pkg::IODT_NOOP, 0);
    end
    issue(8'h90, 8'h00, 8'h00, 10'h380, 4'h0, 11, iodt_pkg::IODT_NOOP, 0);
    issue(8'hB0 | 8'(xs() & 7), 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_MOVE_IMM, 0);
    chk(32'(res_wide), 32'h0);
    issue(8'hB8 | 8'(xs() & 7), 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_MOVE_IMM, 0);
    chk(32'(res_wide), 32'h1);
    issue(8'hA1, 8'h00, 8'h00, 10'h0, 4'h1, 3, iodt_pkg::IODT_MOVE_ACC_LD, 1);
    issue(8'hA3, 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_MOVE_ACC_ST, 1);
    issue(8'h0F, 8'hB6, 8'hC0, 10'h0, 4'h0, 3, iodt_pkg::IODT_EXTEND, 0);
    chk(32'(res_zext), 32'h1);
    issue(8'h0F, 8'hBE, 8'h00, 10'h0, 4'h1, 5, iodt_pkg::IODT_EXTEND, 1);
    chk(32'(res_zext), 32'h0);
    issue(8'h50 | 8'(xs() & 7), 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_PUSH_REG, 0);
    issue(8'hFF, 8'h30, 8'h00, 10'h0, 4'h1, 5, iodt_pkg::IODT_PUSH_MEM, 1);
    issue(8'h58 | 8'(xs() & 7), 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_POP_REG, 0);
    issue(8'h8F, 8'h00, 8'h00, 10'h0, 4'h1, 7, iodt_pkg::IODT_POP_MEM, 1);
    issue(8'h91 + 8'(xs() % 7), 8'h00, 8'h00, 10'h0, 4'h0, 3, iodt_pkg::IODT_EXCH_REG, 0);
    issue(8'h87, 8'hC0, 8'h00, 10'h0, 4'h0, 3, iodt_pkg::IODT_EXCH_REG, 0);
    issue(8'h87, 8'h00, 8'h00, 10'h0, 4'h0, 5, iodt_pkg::IODT_EXCH_MEM, 1);
    issue(8'h8D, 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_LEA, -1);
    issue(8'h8D, 8'h04, 8'h08, 10'h0, 4'h0, 2, iodt_pkg::IODT_LEA, -1);
    issue(8'h60, 8'h00, 8'h00, 10'h0, 4'h0, 11, iodt_pkg::IODT_PUSH_ALL, 0);
    issue(8'h6A, 8'h00, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_PUSH_IMM, 0);
    // Stack reads: bus cycle expected without a memory operand
    issue(8'h61, 8'h00, 8'h00, 10'h0, 4'h1, 16, iodt_pkg::IODT_POP_ALL, 2);
    @(posedge clk);
    op_size32 <= 1'b1;
    seq_unaligned <= 1'b1;
    issue(8'h61, 8'h00, 8'h00, 10'h0, 4'h1, 29, iodt_pkg::IODT_POP_ALL, 2);
    issue(8'hC7, 8'h05, 8'h00, 10'h0, 4'h0, 1, iodt_pkg::IODT_MOVE_IMM, 1);
    issue(8'h01, 8'h00, 8'h00, 10'h80, 4'h0, 0, iodt_pkg::IODT_UNKNOWN, -1);
    @(posedge clk);
    ce <= 1'b0;
    dec_valid <= 1'b1;
    @(posedge clk);
    ce <= 1'b1;
    dec_valid <= 1'b0;
    #1;
    chk(32'(res_valid), 32'h0);
    // Index and displacement-immediate penalties on, first read five clocks
    wr(8'h00, 32'hFFFF_F215);
    rd(8'h00, 32'h0000_3215);
    issue(8'hC7, 8'h05, 8'h00, 10'h0, 4'h0, 2, iodt_pkg::IODT_MOVE_IMM, 1);
    issue(8'h8B, 8'h04, 8'h08, 10'h0, 4'h0, 2, iodt_pkg::IODT_MOVE_LOAD, 1);
    issue(8'h8B, 8'h00, 8'h00, 10'h0, 4'h1, 6, iodt_pkg::IODT_MOVE_LOAD, 1);
    test_done();
  end
endmodule // tb_integer_op_decode_timing
